//--- stdc_pkg.sv
// Package with register map, field layout and timing constants for the tick down-counter
package stdc_pkg;
   // Register byte offsets (mask is a local addition)
   localparam logic [3:0]  CTRL_OFFSET       = 4'h0;
   localparam logic [3:0]  RESTART_OFFSET    = 4'h4;
   localparam logic [3:0]  LIVE_OFFSET       = 4'h8;
   localparam logic [3:0]  REFERENCE_OFFSET  = 4'hC;
   localparam logic [4:0]  MASK_OFFSET       = 5'h10;
   localparam int          ADDR_W            = 5;
   // Control and status field positions
   localparam int          ENABLE_BIT        = 0;
   localparam int          IRQ_ENABLE_BIT    = 1;
   localparam int          SOURCE_BIT        = 2;
   localparam int          ZERO_FLAG_BIT     = 16;
   // Reset values
   localparam logic [2:0]  CTRL_RESET        = 3'h4;
   localparam logic [23:0] COUNT_RESET       = 24'h000000;
   // Fixed reference count and counter width
   localparam logic [23:0] TEN_MS_COUNT      = 24'h001F40;
   localparam int          COUNT_W           = 24;
   // Prescaler ratio for the slow source
   localparam int          PRESCALE_DIV      = 8;
   // AXI responses
   localparam logic [1:0]  RESP_OKAY         = 2'h0;
   localparam logic [1:0]  RESP_SLVERR       = 2'h2;
endpackage

//--- stdc_prescaler.sv
// Tick prescaler producing the counter-clock enable pulse
`timescale 1ns/1ps
`default_nettype none
module stdc_prescaler #(
   parameter int DIV = stdc_pkg::PRESCALE_DIV
) (
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic reset_i,
   // Control
   input  wire logic run_i,
   input  wire logic fast_i,
   // Count enable
   output logic      tick_o
);
   import stdc_pkg::*;
   localparam int  DW = $clog2(DIV);
   logic [DW-1:0]  div_cnt;
   logic [DW-1:0]  next_div_cnt;

   // Divider free-runs only while counting; phase restarts on disable
   always_comb begin
      if (!run_i) begin
         next_div_cnt = '0;
      end else if (div_cnt == DW'(DIV - 1)) begin
         next_div_cnt = '0;
      end else begin
         next_div_cnt = div_cnt + DW'(1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         div_cnt <= '0;
      end else begin
         div_cnt <= next_div_cnt;
      end
   end

   // Full rate or one in DIV cycles
   assign tick_o = run_i && (fast_i || (div_cnt == DW'(DIV - 1))); // see RQ16
endmodule
`default_nettype wire

//--- stdc_top.sv
// Tick down-counter with AXI4-Lite register slave and interrupt
//
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// RQ1 - Load restart value on enable and zero
// RQ2 - Restart value is 24 bits, upper reserved
// RQ3 - Flag and request only on 1-to-0
// RQ4 - Software: N-1 gives period N
// RQ5 - Software: N gives one-shot after N
// RQ6 - Live count read returns counter value
// RQ7 - Live count write zeroes counter and flag
// RQ8 - Reference field reads fixed 0x1F40
// RQ9 - Counter advances only on processor clock
// RQ10 - Software uses aligned word accesses only
// RQ11 - Reference flags read zero, writes ignored
// RQ12 - Upper eight bits read zero
// RQ13 - Decrement per tick, wrap to restart
// RQ14 - Zero flag set until control read
// RQ15 - Irq enable gates exception request
// RQ16 - Source select: 0 divided, 1 full
module stdc_top (
   // Clock and reset
   input  wire logic                         clk_i,
   input  wire logic                         reset_i,
   // AXI4-Lite write address
   input  wire logic [stdc_pkg::ADDR_W-1:0]  s_axi_awaddr_i,
   input  wire logic                         s_axi_awvalid_i,
   output logic                              s_axi_awready_o,
   // AXI4-Lite write data
   input  wire logic [31:0]                  s_axi_wdata_i,
   input  wire logic [3:0]                   s_axi_wstrb_i,
   input  wire logic                         s_axi_wvalid_i,
   output logic                              s_axi_wready_o,
   // AXI4-Lite write response
   output logic [1:0]                        s_axi_bresp_o,
   output logic                              s_axi_bvalid_o,
   input  wire logic                         s_axi_bready_i,
   // AXI4-Lite read address
   input  wire logic [stdc_pkg::ADDR_W-1:0]  s_axi_araddr_i,
   input  wire logic                         s_axi_arvalid_i,
   output logic                              s_axi_arready_o,
   // AXI4-Lite read data
   output logic [31:0]                       s_axi_rdata_o,
   output logic [1:0]                        s_axi_rresp_o,
   output logic                              s_axi_rvalid_o,
   input  wire logic                         s_axi_rready_i,
   // Interrupt and exception request
   output logic                              irq_o,
   output logic                              tick_req_o
);
   import stdc_pkg::*;

   // Control state
   logic               count_enable;
   logic               tick_irq_enable;
   logic               tick_source_select;
   logic               zero_reached_flag;
   logic               zero_mask;
   logic [COUNT_W-1:0] restart_value;
   logic [COUNT_W-1:0] live_count;
   logic               tick_req;
   logic               next_count_enable;
   logic               next_tick_irq_enable;
   logic               next_tick_source_select;
   logic               next_zero_reached_flag;
   logic               next_zero_mask;
   logic [COUNT_W-1:0] next_restart_value;
   logic [COUNT_W-1:0] next_live_count;
   logic               next_tick_req;
   // Bus state
   logic               aw_held;
   logic               w_held;
   logic [ADDR_W-1:0]  aw_addr;
   logic [31:0]        w_data;
   logic               bvalid;
   logic [1:0]         bresp;
   logic               rvalid;
   logic [31:0]        rdata;
   logic [1:0]         rresp;
   logic               next_aw_held;
   logic               next_w_held;
   logic [ADDR_W-1:0]  next_aw_addr;
   logic [31:0]        next_w_data;
   logic               next_bvalid;
   logic [1:0]         next_bresp;
   logic               next_rvalid;
   logic [31:0]        next_rdata;
   logic [1:0]         next_rresp;
   // Derived strobes
   logic               wr_fire;
   logic               rd_fire;
   logic               count_tick;
   logic               hit_zero;
   logic               start_pulse;
   logic               prev_enable;
   logic [31:0]        rd_word;
   logic               rd_ok;

   // Full word map check; unaligned or unmapped addresses are refused, write strobes are not examined
   function automatic logic mapped(input logic [ADDR_W-1:0] a);
      mapped = (a == {1'b0, CTRL_OFFSET}) || (a == {1'b0, RESTART_OFFSET}) ||
               (a == {1'b0, LIVE_OFFSET}) || (a == {1'b0, REFERENCE_OFFSET}) ||
               (a == MASK_OFFSET);
   endfunction

   // Prescaler: enable pulse at full or divided rate
   stdc_prescaler #(
      .DIV     (PRESCALE_DIV)
   ) u_prescaler (
      .clk_i   (clk_i),
      .reset_i (reset_i),
      .run_i   (count_enable),
      .fast_i  (tick_source_select),
      .tick_o  (count_tick)
   );

   // Write fires once address and data are both held and no response pends
   assign wr_fire     = aw_held && w_held && !bvalid;
   assign rd_fire     = s_axi_arvalid_i && s_axi_arready_o;
   assign start_pulse = count_enable && !prev_enable;
   // Event only when a real tick takes the count from one to zero
   assign hit_zero    = count_tick && !start_pulse && (live_count == COUNT_W'(1)); // see RQ3

   // Read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      rd_ok   = mapped(s_axi_araddr_i);
      if (s_axi_araddr_i == {1'b0, CTRL_OFFSET}) begin
         rd_word[ENABLE_BIT]     = count_enable;
         rd_word[IRQ_ENABLE_BIT] = tick_irq_enable;
         rd_word[SOURCE_BIT]     = tick_source_select;
         rd_word[ZERO_FLAG_BIT]  = zero_reached_flag;
      end else if (s_axi_araddr_i == {1'b0, RESTART_OFFSET}) begin
         rd_word = {8'h00, restart_value}; // see RQ12
      end else if (s_axi_araddr_i == {1'b0, LIVE_OFFSET}) begin
         rd_word = {8'h00, live_count}; // see RQ6
      end else if (s_axi_araddr_i == {1'b0, REFERENCE_OFFSET}) begin
         rd_word = {8'h00, TEN_MS_COUNT}; // see RQ8, RQ11
      end else if (s_axi_araddr_i == MASK_OFFSET) begin
         rd_word[ZERO_FLAG_BIT]  = zero_mask;
      end
   end

   // Bus channel next state; one write and one read in flight
   always_comb begin
      next_aw_held = aw_held;
      next_w_held  = w_held;
      next_aw_addr = aw_addr;
      next_w_data  = w_data;
      next_bvalid  = bvalid;
      next_bresp   = bresp;
      next_rvalid  = rvalid;
      next_rdata   = rdata;
      next_rresp   = rresp;
      if (s_axi_awvalid_i && s_axi_awready_o) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata_i;
      end
      if (wr_fire) begin
         next_aw_held = 1'b0;
         next_w_held  = 1'b0;
         next_bvalid  = 1'b1;
         next_bresp   = mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR; // see RQ10
      end else if (bvalid && s_axi_bready_i) begin
         next_bvalid  = 1'b0;
      end
      if (rd_fire) begin
         next_rvalid = 1'b1;
         next_rdata  = rd_word;
         next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && s_axi_rready_i) begin
         next_rvalid = 1'b0;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         aw_held <= 1'b0;
         w_held  <= 1'b0;
         aw_addr <= '0;
         w_data  <= 32'h0000_0000;
         bvalid  <= 1'b0;
         bresp   <= RESP_OKAY;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= RESP_OKAY;
      end else begin
         aw_held <= next_aw_held;
         w_held  <= next_w_held;
         aw_addr <= next_aw_addr;
         w_data  <= next_w_data;
         bvalid  <= next_bvalid;
         bresp   <= next_bresp;
         rvalid  <= next_rvalid;
         rdata   <= next_rdata;
         rresp   <= next_rresp;
      end
   end

   // Counter and control next state
   always_comb begin
      next_count_enable       = count_enable;
      next_tick_irq_enable    = tick_irq_enable;
      next_tick_source_select = tick_source_select;
      next_zero_mask          = zero_mask;
      next_restart_value      = restart_value;
      next_live_count         = live_count;
      next_zero_reached_flag  = zero_reached_flag;
      next_tick_req           = hit_zero && tick_irq_enable; // see RQ15
      // Counting: load on start, wrap at zero, else decrement
      if (start_pulse) begin
         next_live_count = restart_value; // see RQ1
      end else if (count_tick) begin
         if (live_count == COUNT_W'(0)) begin
            next_live_count = restart_value; // see RQ1, RQ13
         end else begin
            next_live_count = live_count - COUNT_W'(1); // see RQ13
         end
      end
      // Control read clears the flag; a same-cycle event wins
      if (rd_fire && (s_axi_araddr_i == {1'b0, CTRL_OFFSET})) begin
         next_zero_reached_flag = 1'b0; // see RQ14
      end
      // Register writes; upper bits dropped, reference ignores writes
      if (wr_fire) begin
         if (aw_addr == {1'b0, CTRL_OFFSET}) begin
            next_count_enable       = w_data[ENABLE_BIT];
            next_tick_irq_enable    = w_data[IRQ_ENABLE_BIT];
            next_tick_source_select = w_data[SOURCE_BIT]; // see RQ16
         end else if (aw_addr == {1'b0, RESTART_OFFSET}) begin
            next_restart_value = w_data[COUNT_W-1:0]; // see RQ2, RQ12
         end else if (aw_addr == {1'b0, LIVE_OFFSET}) begin
            next_live_count        = COUNT_W'(0); // see RQ7
            next_zero_reached_flag = 1'b0; // see RQ7
         end else if (aw_addr == MASK_OFFSET) begin
            next_zero_mask = w_data[ZERO_FLAG_BIT];
         end
      end
      if (hit_zero) begin
         next_zero_reached_flag = 1'b1; // see RQ3, RQ14
      end
   end

   // Only clk_i edges move the counter, so a gated clock holds it
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         count_enable       <= CTRL_RESET[ENABLE_BIT];
         tick_irq_enable    <= CTRL_RESET[IRQ_ENABLE_BIT];
         tick_source_select <= CTRL_RESET[SOURCE_BIT];
         zero_reached_flag  <= 1'b0;
         zero_mask          <= 1'b0;
         restart_value      <= COUNT_RESET;
         live_count         <= COUNT_RESET;
         tick_req           <= 1'b0;
         prev_enable        <= 1'b0;
      end else begin
         count_enable       <= next_count_enable;
         tick_irq_enable    <= next_tick_irq_enable;
         tick_source_select <= next_tick_source_select;
         zero_reached_flag  <= next_zero_reached_flag;
         zero_mask          <= next_zero_mask;
         restart_value      <= next_restart_value;
         live_count         <= next_live_count; // see RQ9
         tick_req           <= next_tick_req;
         prev_enable        <= count_enable;
      end
   end

   // Outputs; ready only while nothing of that kind pends
   assign s_axi_awready_o = !aw_held;
   assign s_axi_wready_o  = !w_held;
   assign s_axi_bvalid_o  = bvalid;
   assign s_axi_bresp_o   = bresp;
   assign s_axi_arready_o = !rvalid;
   assign s_axi_rvalid_o  = rvalid;
   assign s_axi_rdata_o   = rdata;
   assign s_axi_rresp_o   = rresp;
   assign tick_req_o      = tick_req;
   assign irq_o           = zero_reached_flag && zero_mask;

   // Checks
   start_load_a: assert property (@(posedge clk_i) disable iff (reset_i)
      start_pulse |=> live_count == $past(restart_value)) // see RQ1
      else $error("restart value not loaded at enable");
   flag_onezero_a: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(zero_reached_flag) |-> $past(live_count) == COUNT_W'(1)) // see RQ3
      else $error("zero flag set without 1 to 0 step");
   live_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_fire && s_axi_araddr_i == {1'b0, LIVE_OFFSET} |=> rdata == {8'h00, $past(live_count)}) // see RQ6
      else $error("live count read wrong");
   live_write_a: assert property (@(posedge clk_i) disable iff (reset_i)
      wr_fire && aw_addr == {1'b0, LIVE_OFFSET} && !hit_zero |=> live_count == 24'h000000 && !zero_reached_flag) // see RQ7
      else $error("live count write did not clear");
   ref_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_fire && s_axi_araddr_i == {1'b0, REFERENCE_OFFSET} |=> rdata == 32'h0000_1F40) // see RQ8, RQ11
      else $error("reference register wrong");
   upper_zero_a: assert property (@(posedge clk_i) disable iff (reset_i)
      rvalid && (rdata != 32'h0000_1F40) && rresp == RESP_OKAY |-> rdata[31:24] == 8'h00) // see RQ12
      else $error("upper bits not zero");
   count_step_a: assert property (@(posedge clk_i) disable iff (reset_i)
      count_tick && !start_pulse && !wr_fire && live_count != 24'h000000 |=> live_count == $past(live_count) - 24'h000001) // see RQ13
      else $error("counter did not decrement");
   slow_rate_a: assert property (@(posedge clk_i) disable iff (reset_i)
      count_tick && !tick_source_select && $stable(count_enable) |=> (!count_tick || tick_source_select) [*7]) // see RQ16
      else $error("divided tick too fast");
   tick_gate_a: assert property (@(posedge clk_i) disable iff (reset_i)
      tick_req |-> $past(tick_irq_enable) && $past(hit_zero)) // see RQ15
      else $error("tick request without cause");
   flag_read_a: assert property (@(posedge clk_i) disable iff (reset_i)
      rd_fire && s_axi_araddr_i == {1'b0, CTRL_OFFSET} && !hit_zero |=> !zero_reached_flag) // see RQ14
      else $error("control read did not clear flag");
endmodule
`default_nettype wire

//--- stdc_top_tb.sv
// Self-checking testbench for the tick down-counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin checks++; if ((got) !== (exp)) begin error_cnt++; \
   $display("unexpected %s: expected %0h seen %0h", nm, exp, got); end end
module stdc_top_tb;
   import stdc_pkg::*;
   // Clock, reset and bus
   logic        clk_i   = 1'b0;
   logic        reset_i = 1'b1;
   logic [4:0]  awaddr  = 5'h00;
   logic        awvalid = 1'b0;
   logic        awready;
   logic [31:0] wdata   = 32'h0;
   logic        wvalid  = 1'b0;
   logic        wready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready  = 1'b0;
   logic [4:0]  araddr  = 5'h00;
   logic        arvalid = 1'b0;
   logic        arready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready  = 1'b0;
   logic        irq_o;
   logic        tick_req_o;
   int          error_cnt = 0;
   int          checks    = 0;
   int          cyc       = 0;
   int          rd_t      = 0;
   // Register addresses, widened to the bus width
   localparam logic [4:0] A_CTL = {1'b0, CTRL_OFFSET};
   localparam logic [4:0] A_RST = {1'b0, RESTART_OFFSET};
   localparam logic [4:0] A_LIV = {1'b0, LIVE_OFFSET};
   localparam logic [4:0] A_REF = {1'b0, REFERENCE_OFFSET};

   always #20 clk_i = ~clk_i;
   // Cycle stamp, updated late so tasks see a stable value
   always @(posedge clk_i) cyc <= cyc + 1;

   stdc_top u_dut (
      .clk_i(clk_i), .reset_i(reset_i),
      .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
      .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
      .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
      .irq_o(irq_o), .tick_req_o(tick_req_o)
   );

   // Expected tick spacing: restart+1 counts, each one or eight clocks long
   function automatic int exp_gap(input int src, input int r);
      return (src != 0) ? (r + 1) : PRESCALE_DIV * (r + 1);
   endfunction

   function automatic logic [31:0] ctl_word(input int en, input int ie, input int src);
      return (32'(en) << ENABLE_BIT) | (32'(ie) << IRQ_ENABLE_BIT) | (32'(src) << SOURCE_BIT);
   endfunction

   // One write; address and data offered together, each dropped when taken
   task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] er);
      logic [1:0] resp;
      resp = 2'h3;
      @(posedge clk_i);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            resp = bresp;
            break;
         end
      end
      bready <= 1'b0;
      `CHK("bresp", er, resp)
   endtask

   // One read; stamps the cycle at which the answer was taken
   task automatic rd(input logic [4:0] a, input logic [1:0] er, output logic [31:0] d);
      logic [1:0] resp;
      resp = 2'h3;
      d = 32'hDEADBEEF;
      @(posedge clk_i);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int n = 0; n < 50; n++) begin
         @(posedge clk_i);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            resp = rresp;
            d = rdata;
            rd_t = cyc;
            break;
         end
      end
      rready <= 1'b0;
      `CHK("rresp", er, resp)
   endtask

   // Distance in clocks between the first two exception pulses, -1 if fewer
   task automatic tick_gap(input int lim, output int gap);
      int t0;
      t0 = -1;
      gap = -1;
      for (int i = 0; i < lim; i++) begin
         @(posedge clk_i);
         if (tick_req_o === 1'b1) begin
            if (t0 >= 0) begin
               gap = i - t0;
               break;
            end
            t0 = i;
         end
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   // Watchdog: the sequence needs a few thousand clocks at most
   initial begin
      #800000;
      error_cnt++;
      summarize();
   end

   initial begin
      logic [31:0] d, r;
      logic [23:0] dl;
      logic [4:0]  at[5];
      logic [31:0] rt[5];
      int          g, t1, rv, src;
      at = '{A_CTL, A_RST, A_LIV, A_REF, MASK_OFFSET};
      rt = '{{29'h0, CTRL_RESET}, 32'h0, 32'h0, {8'h00, TEN_MS_COUNT}, 32'h0};
      void'($urandom(32'hf1c9cecf));
      repeat (10) @(posedge clk_i);
      reset_i <= 1'b0;
      // Reset contents of every register
      for (int i = 0; i < 5; i++) begin
         rd(at[i], RESP_OKAY, d);
         `CHK("reset value", rt[i], d)
      end
      // Reference ignores writes, restart keeps only 24 bits
      wr(A_REF, $urandom, RESP_OKAY);
      rd(A_REF, RESP_OKAY, d);
      `CHK("reference", {8'h00, TEN_MS_COUNT}, d)
      r = $urandom;
      wr(A_RST, r, RESP_OKAY);
      rd(A_RST, RESP_OKAY, d);
      `CHK("restart", {8'h00, r[23:0]}, d)
      // Unmapped and unaligned places are refused
      foreach (at[i]) if (i < 2) begin
         wr(i == 0 ? 5'h14 : 5'h06, $urandom, RESP_SLVERR);
         rd(i == 0 ? 5'h14 : 5'h06, RESP_SLVERR, d);
         `CHK("refused data", 32'h0, d)
      end
      $display("test registers done");
      // Periodic ticks on both sources, shortest restart first
      for (int k = 0; k < 6; k++) begin
         src = k % 2;
         rv = (k < 2) ? 1 : int'($urandom_range(src != 0 ? 40 : 6, 2));
         wr(A_RST, 32'(rv), RESP_OKAY);
         wr(A_CTL, ctl_word(1, 1, src), RESP_OKAY);
         tick_gap(3 * exp_gap(src, rv), g);
         `CHK("tick gap", exp_gap(src, rv), g)
         wr(A_CTL, 32'h0, RESP_OKAY);
      end
      $display("test period done");
      // Sticky flag, mask and read clear
      `CHK("irq unmasked", 1'b0, irq_o)
      wr(MASK_OFFSET, 32'h1 << ZERO_FLAG_BIT, RESP_OKAY);
      `CHK("irq masked in", 1'b1, irq_o)
      rd(A_CTL, RESP_OKAY, d);
      `CHK("flag set", 32'h1 << ZERO_FLAG_BIT, d)
      @(posedge clk_i);
      `CHK("irq after read", 1'b0, irq_o)
      rd(A_CTL, RESP_OKAY, d);
      `CHK("flag cleared", 32'h0, d)
      $display("test flag done");
      // Request disabled: flag still sets, live write clears it
      wr(A_RST, 32'h3, RESP_OKAY);
      wr(A_CTL, ctl_word(1, 0, 1), RESP_OKAY);
      tick_gap(24, g);
      `CHK("no request", -1, g)
      wr(A_CTL, 32'h0, RESP_OKAY);
      `CHK("irq flag only", 1'b1, irq_o)
      wr(A_LIV, $urandom, RESP_OKAY);
      rd(A_LIV, RESP_OKAY, d);
      `CHK("live cleared", 32'h0, d)
      rd(A_CTL, RESP_OKAY, d);
      `CHK("flag by write", 32'h0, d)
      $display("test live write done");
      // Restart of zero gives no event
      wr(A_RST, 32'h0, RESP_OKAY);
      wr(A_CTL, ctl_word(1, 1, 1), RESP_OKAY);
      tick_gap(40, g);
      `CHK("zero restart", -1, g)
      rd(A_CTL, RESP_OKAY, d);
      `CHK("zero no flag", ctl_word(1, 1, 1), d)
      wr(A_CTL, 32'h0, RESP_OKAY);
      $display("test zero restart done");
      // One-shot: restart N gives the first request N clocks after the restart value loads, one clock after the enable lands
      rv = int'($urandom_range(20, 3));
      wr(A_RST, 32'(rv), RESP_OKAY);
      wr(A_CTL, ctl_word(1, 1, 1), RESP_OKAY);
      g = -1;
      for (int i = 0; i < 2 * rv && g < 0; i++) begin
         @(posedge clk_i);
         if (tick_req_o === 1'b1) g = i;
      end
      `CHK("one-shot delay", rv, g)
      wr(A_CTL, 32'h0, RESP_OKAY);
      $display("test one-shot done");
      // Live count follows the clock between two reads
      wr(A_RST, 32'h00FFFFFF, RESP_OKAY);
      wr(A_CTL, ctl_word(1, 0, 1), RESP_OKAY);
      rd(A_LIV, RESP_OKAY, d);
      t1 = rd_t;
      repeat ($urandom_range(9, 1)) @(posedge clk_i);
      rd(A_LIV, RESP_OKAY, r);
      dl = d[23:0] - r[23:0];
      `CHK("live delta", 24'(rd_t - t1), dl)
      `CHK("live upper", 8'h00, r[31:24])
      $display("test live read done");
      summarize();
   end
endmodule
`default_nettype wire
